// *** hdl/dual_timer_pkg.sv ***
// Constants and the bus request type for the dual down-counter timer block
// Operation
// R1: Narrow timeout irq enable; 0 after reset, kept in stop recovery.
// R2: Pin select 1 drives narrow output on port3 bit4; 0 leaves port data.
// R3: Writing 1 to narrow enable starts the narrow timer.
// R4: Count mode 0 reloads at terminal count; 1 stops the counter.
// R5: Narrow timeout flag set at terminal count; only a written 1 clears it.
// R6: Software clears terminal count flags before using the timers.
// R7: First prescaled tick after enable may come early or short.
// R8: Software beware read-modify-write on status and demodulation bits.
// R9: Narrow clock select field sets the narrow timer input rate.
// R10: Clock codes 00 sysclk, 01 div2, 10 div4, 11 div8.
// R11: Wide control D6 set: wide timer ignores later edges, keeps counting.
// R12: There, narrow timeout captures wide count, no reload; D2 enables irq.
// R13: D6 written 0 then 1 arms capture and reload on next selected edge.
// R14: Wide timer wraps from zero to FFFF, sets D5, D1 enables interrupt.
// R15: Ping-pong in transmit mode only, both single-pass, started by enable.
// R16: Narrow start takes level from shared D1; level picks high or low reload.
// R17: Narrow terminal count hands over to wide timer with level from D0.
// R18: Each terminal count in ping-pong raises irq if own D1 set.
// R19: Writing 00 to shared mode bits ends ping-pong operation.
// R20: Software stops timers and clears flags before entering ping-pong.
// R21: Software writes mode bits in any order, enable last.
// R22: Software never programs an initial count of 1 in ping-pong.
// R23: Stop then enable reloads the programmed initial value.
package dual_timer_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_NARROW_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHARED_CTRL = 8'h04;
  localparam logic [7:0] OFS_WIDE_CTRL   = 8'h08;
  localparam logic [7:0] OFS_N_RELOAD_HI = 8'h0C;
  localparam logic [7:0] OFS_N_RELOAD_LO = 8'h10;
  localparam logic [7:0] OFS_W_RELOAD_HI = 8'h14;
  localparam logic [7:0] OFS_W_RELOAD_LO = 8'h18;
  localparam logic [7:0] OFS_CAPTURE     = 8'h1C;
  // Control bit positions, same for both timers
  localparam int B_ENABLE  = 7;
  localparam int B_SINGLE  = 6;
  localparam int B_TIMEOUT = 5;
  localparam int B_CLKSEL  = 3;
  localparam int B_CAP_IE  = 2;
  localparam int B_TO_IE   = 1;
  localparam int B_PIN_SEL = 0;
  // Shared control bit positions
  localparam int B_TRANSMIT = 7;
  localparam int B_EDGE     = 4;
  localparam int B_MODE     = 2;
  localparam int B_N_INIT   = 1;
  localparam int B_W_INIT   = 0;
  // Stored config bits, and those kept in stop recovery
  localparam logic [7:0] N_CFG_MASK = 8'h5F;
  localparam logic [7:0] W_CFG_MASK = 8'h46;
  localparam logic [7:0] N_SMR_KEEP = 8'h1E;
  // Reset values
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_RELOAD  = 8'h00;
  localparam logic [15:0] RST_COUNT   = 16'h0000;
  // Shared mode codes
  localparam logic [1:0] MODE_NONE     = 2'b00;
  localparam logic [1:0] MODE_PINGPONG = 2'b01;
  // Edge select codes
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_FALL = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  // Clock select codes
  localparam logic [1:0] CLK_DIV1 = 2'b00;
  localparam logic [1:0] CLK_DIV2 = 2'b01;
  localparam logic [1:0] CLK_DIV4 = 2'b10;
  localparam logic [1:0] CLK_DIV8 = 2'b11;
  // Latched AHB address phase
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
  } bus_req_s;
endpackage

// *** hdl/timer_prescaler.sv ***
// Free-running divider giving the narrow timer its input tick
`timescale 1ns/10ps
`default_nettype none
module timer_prescaler (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // Divider select and tick
  input  wire logic [1:0]                sel,
  output logic                           tick
);
  import dual_timer_pkg::*;

  logic [2:0] div_reg;
  logic [2:0] mask;

  // Divider runs free, so the first tick after an enable lands anywhere
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) div_reg <= 3'h0;
    else          div_reg <= div_reg + 3'h1; // R7
  end

  // Tick when the low bits of the divider are all ones
  assign mask = (sel == CLK_DIV1) ? 3'h0 :
                (sel == CLK_DIV2) ? 3'h1 :
                (sel == CLK_DIV4) ? 3'h3 : 3'h7; // R10
  assign tick = ((div_reg & mask) == mask); // R9
endmodule
`default_nettype wire

// *** hdl/carrier_edge_detect.sv ***
// Synchroniser and selectable edge detector for the carrier input
`timescale 1ns/10ps
`default_nettype none
module carrier_edge_detect (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // Pin and selection
  input  wire logic                      carrier_in,
  input  wire logic [1:0]                edge_sel,
  // Edge pulse
  output logic                           edge_seen
);
  import dual_timer_pkg::*;

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;
  logic rise;
  logic fall;

  // Two sync flops, then one for edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= carrier_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // Edge select decode
  assign rise      = sync_reg & ~prev_reg;
  assign fall      = ~sync_reg & prev_reg;
  assign edge_seen = ((edge_sel == EDGE_RISE) & rise) |
                     ((edge_sel == EDGE_FALL) & fall) |
                     ((edge_sel == EDGE_BOTH) & (rise | fall)); // R13
endmodule
`default_nettype wire

// *** hdl/dual_timer.sv ***
// Dual down-counter timer with capture and ping-pong, AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
module dual_timer (
  // Clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // AHB-Lite slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // Power management
  input  wire logic                      stop_recovery,
  // Carrier and port pins
  input  wire logic                      carrier_in,
  input  wire logic                      port3_bit4_data,
  output logic                           port3_bit4_pin,
  output logic                           narrow_output_level,
  output logic                           wide_output_level,
  // Interrupt requests
  output logic                           narrow_timeout_irq,
  output logic                           wide_timeout_irq,
  output logic                           wide_capture_irq
);
  import dual_timer_pkg::*;

  bus_req_s    req_reg;
  logic [31:0] hrdata_reg;
  logic [7:0]  n_cfg_reg;
  logic        n_run_reg;
  logic        n_flag_reg;
  logic [7:0]  n_cnt_reg;
  logic        n_level_reg;
  logic [7:0]  shared_reg;
  logic [7:0]  w_cfg_reg;
  logic        w_run_reg;
  logic        w_flag_reg;
  logic [15:0] w_cnt_reg;
  logic        w_level_reg;
  logic        w_arm_reg;
  logic [15:0] cap_reg;
  logic        cap_pulse_reg;
  logic [7:0]  n_hi_reg;
  logic [7:0]  n_lo_reg;
  logic [7:0]  w_hi_reg;
  logic [7:0]  w_lo_reg;
  logic        pin_reg;

  logic        addr_phase;
  logic        wr_n_ctrl;
  logic        wr_shared;
  logic        wr_w_ctrl;
  logic        wr_n_hi;
  logic        wr_n_lo;
  logic        wr_w_hi;
  logic        wr_w_lo;
  logic [7:0]  wd;
  logic [31:0] rd_word;
  logic        tick;
  logic        edge_seen;
  logic        xmit;
  logic        pp;
  logic        n_single;
  logic        w_single;
  logic        n_tc;
  logic        w_tc;
  logic        n_start;
  logic        w_start;
  logic        n_reload;
  logic        w_reload;
  logic [7:0]  n_init;
  logic [7:0]  n_next_load;
  logic [15:0] w_init;
  logic        rx_capture;
  logic        edge_capture;
  logic        tc_capture;
  logic        w_arm_set;

  // Narrow timer input clock
  timer_prescaler u_prescaler (
    .hclk    (hclk),
    .hresetn (hresetn),
    .sel     (n_cfg_reg[B_CLKSEL +: 2]),
    .tick    (tick)
  );

  // Carrier edge pulses for the wide timer
  carrier_edge_detect u_edge (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .carrier_in (carrier_in),
    .edge_sel   (shared_reg[B_EDGE +: 2]),
    .edge_seen  (edge_seen)
  );

  // No wait states and no errors
  assign addr_phase = hsel & htrans[1] & hready;
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_reg;

  // Address phase is latched, the write lands in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_reg <= '0;
    end else begin
      req_reg.write <= addr_phase & hwrite;
      req_reg.read  <= addr_phase & ~hwrite;
      req_reg.addr  <= haddr[7:0];
    end
  end

  // Write strobes per register
  assign wd        = hwdata[7:0];
  assign wr_n_ctrl = req_reg.write & (req_reg.addr == OFS_NARROW_CTRL);
  assign wr_shared = req_reg.write & (req_reg.addr == OFS_SHARED_CTRL);
  assign wr_w_ctrl = req_reg.write & (req_reg.addr == OFS_WIDE_CTRL);
  assign wr_n_hi   = req_reg.write & (req_reg.addr == OFS_N_RELOAD_HI);
  assign wr_n_lo   = req_reg.write & (req_reg.addr == OFS_N_RELOAD_LO);
  assign wr_w_hi   = req_reg.write & (req_reg.addr == OFS_W_RELOAD_HI);
  assign wr_w_lo   = req_reg.write & (req_reg.addr == OFS_W_RELOAD_LO);

  // Read mux; unmapped offsets and upper bits read zero
  assign rd_word =
    (haddr[7:0] == OFS_NARROW_CTRL) ?
      {24'h0, n_run_reg, n_cfg_reg[6], n_flag_reg, n_cfg_reg[4:0]} :
    (haddr[7:0] == OFS_SHARED_CTRL) ? {24'h0, shared_reg} :
    (haddr[7:0] == OFS_WIDE_CTRL) ?
      {24'h0, w_run_reg, w_cfg_reg[6], w_flag_reg, w_cfg_reg[4:0]} :
    (haddr[7:0] == OFS_N_RELOAD_HI) ? {24'h0, n_hi_reg} :
    (haddr[7:0] == OFS_N_RELOAD_LO) ? {24'h0, n_lo_reg} :
    (haddr[7:0] == OFS_W_RELOAD_HI) ? {24'h0, w_hi_reg} :
    (haddr[7:0] == OFS_W_RELOAD_LO) ? {24'h0, w_lo_reg} :
    (haddr[7:0] == OFS_CAPTURE) ? {16'h0, cap_reg} : 32'h0;

  // Read data taken at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                  hrdata_reg <= 32'h0;
    else if (addr_phase & ~hwrite) hrdata_reg <= rd_word;
  end

  // Mode decode
  assign xmit     = shared_reg[B_TRANSMIT];
  assign pp       = xmit & (shared_reg[B_MODE +: 2] == MODE_PINGPONG); // R15 R19
  assign n_single = n_cfg_reg[B_SINGLE];
  assign w_single = w_cfg_reg[B_SINGLE];

  // Terminal counts
  assign n_tc = n_run_reg & tick & (n_cnt_reg == 8'h00);
  assign w_tc = w_run_reg & (w_cnt_reg == 16'h0000);

  // Starts: enable while stopped, or ping-pong hand-over
  assign n_start = (wr_n_ctrl & wd[B_ENABLE] & ~n_run_reg) |
                   (pp & w_tc); // R3 R17
  assign w_start = (wr_w_ctrl & wd[B_ENABLE] & ~w_run_reg & xmit) |
                   (pp & n_tc); // R15 R17

  // Modulo reload outside ping-pong
  assign n_reload = n_tc & ~n_single & ~pp; // R4
  assign w_reload = w_tc & ~w_single & ~pp & xmit; // R4

  // Start takes the set level, reload the toggled one
  assign n_init      = shared_reg[B_N_INIT] ? n_hi_reg : n_lo_reg; // R16
  assign n_next_load = n_level_reg ? n_lo_reg : n_hi_reg;
  assign w_init      = {w_hi_reg, w_lo_reg}; // R17

  // Receive-side capture events
  assign rx_capture   = ~xmit & w_run_reg;
  assign edge_capture = rx_capture & edge_seen & (~w_single | w_arm_reg); // R11 R13
  assign tc_capture   = rx_capture & w_single & n_tc; // R12
  assign w_arm_set    = wr_w_ctrl & wd[B_SINGLE] & ~w_cfg_reg[B_SINGLE]; // R13

  // Narrow configuration; some bits survive stop recovery
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)           n_cfg_reg <= RST_CTRL; // R1 R2
    else if (wr_n_ctrl)     n_cfg_reg <= wd & N_CFG_MASK;
    else if (stop_recovery) n_cfg_reg <= n_cfg_reg & N_SMR_KEEP; // R1
  end

  // Narrow run state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                    n_run_reg <= 1'b0;
    else if (n_start)                n_run_reg <= 1'b1; // R3
    else if (stop_recovery)          n_run_reg <= 1'b0;
    else if (wr_n_ctrl & ~wd[B_ENABLE]) n_run_reg <= 1'b0;
    else if (n_tc & (n_single | pp)) n_run_reg <= 1'b0; // R4 R17
  end

  // Narrow counter: load on every start so no stale count survives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                n_cnt_reg <= RST_COUNT[7:0];
    else if (n_start)            n_cnt_reg <= n_init; // R23 R16
    else if (n_reload)           n_cnt_reg <= n_next_load; // R4
    else if (n_run_reg & tick & ~n_tc) n_cnt_reg <= n_cnt_reg - 8'h01;
  end

  // Narrow output level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)      n_level_reg <= 1'b0;
    else if (n_start)  n_level_reg <= shared_reg[B_N_INIT]; // R16
    else if (n_reload) n_level_reg <= ~n_level_reg;
  end

  // Narrow timeout flag; a new timeout beats a clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)  n_flag_reg <= 1'b0;
    else if (n_tc) n_flag_reg <= 1'b1; // R5
    else if (wr_n_ctrl & wd[B_TIMEOUT]) n_flag_reg <= 1'b0; // R5
  end

  // Shared control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)       shared_reg <= RST_CTRL;
    else if (wr_shared) shared_reg <= wd; // R19
  end

  // Wide configuration
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)       w_cfg_reg <= RST_CTRL;
    else if (wr_w_ctrl) w_cfg_reg <= wd & W_CFG_MASK;
  end

  // Wide run state; receive enable starts it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)                          w_run_reg <= 1'b0;
    else if (w_start)                      w_run_reg <= 1'b1;
    else if (wr_w_ctrl & wd[B_ENABLE] & ~xmit) w_run_reg <= 1'b1;
    else if (stop_recovery)                w_run_reg <= 1'b0;
    else if (wr_w_ctrl & ~wd[B_ENABLE])    w_run_reg <= 1'b0;
    else if (w_tc & xmit & (w_single | pp)) w_run_reg <= 1'b0; // R17
  end

  // Wide counter; receive mode wraps to all ones
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      w_cnt_reg <= RST_COUNT;
    end else if (w_start | (wr_w_ctrl & wd[B_ENABLE] & ~w_run_reg)) begin
      w_cnt_reg <= w_init; // R23
    end else if (edge_capture) begin
      w_cnt_reg <= w_init; // R13
    end else if (w_reload) begin
      w_cnt_reg <= w_init; // R4
    end else if (w_run_reg & ~(w_tc & xmit)) begin
      w_cnt_reg <= w_cnt_reg - 16'h0001; // R14 R11 R12
    end
  end

  // Wide output level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)      w_level_reg <= 1'b0;
    else if (w_start)  w_level_reg <= shared_reg[B_W_INIT]; // R17
    else if (w_reload) w_level_reg <= ~w_level_reg;
  end

  // Wide timeout flag; set wins over the clearing write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)  w_flag_reg <= 1'b0;
    else if (w_tc) w_flag_reg <= 1'b1; // R14
    else if (wr_w_ctrl & wd[B_TIMEOUT]) w_flag_reg <= 1'b0;
  end

  // Capture arming: one edge after a 0-to-1 write, then edges ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn)          w_arm_reg <= 1'b0;
    else if (w_arm_set)    w_arm_reg <= 1'b1; // R13
    else if (edge_capture) w_arm_reg <= 1'b0; // R11
  end

  // Captured count and its event pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg       <= RST_COUNT;
      cap_pulse_reg <= 1'b0;
    end else begin
      cap_pulse_reg <= edge_capture | tc_capture; // R12
      if (edge_capture | tc_capture) cap_reg <= w_cnt_reg; // R12 R13
    end
  end

  // Reload bytes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_hi_reg <= RST_RELOAD;
      n_lo_reg <= RST_RELOAD;
      w_hi_reg <= RST_RELOAD;
      w_lo_reg <= RST_RELOAD;
    end else begin
      if (wr_n_hi) n_hi_reg <= wd;
      if (wr_n_lo) n_lo_reg <= wd;
      if (wr_w_hi) w_hi_reg <= wd;
      if (wr_w_lo) w_lo_reg <= wd;
    end
  end

  // Port pin mux, registered so the pin never glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) pin_reg <= 1'b0;
    else pin_reg <= n_cfg_reg[B_PIN_SEL] ? n_level_reg : port3_bit4_data; // R2
  end

  // Outputs
  assign port3_bit4_pin      = pin_reg;
  assign narrow_output_level = n_level_reg;
  assign wide_output_level   = w_level_reg;
  assign narrow_timeout_irq  = n_flag_reg & n_cfg_reg[B_TO_IE]; // R1 R18
  assign wide_timeout_irq    = w_flag_reg & w_cfg_reg[B_TO_IE]; // R14 R18
  assign wide_capture_irq    = cap_pulse_reg & w_cfg_reg[B_CAP_IE]; // R12
endmodule
`default_nettype wire

// *** tb/dual_timer_checker.sv ***
// Port-level assertions for the dual down-counter timer
`timescale 1ns/10ps
`default_nettype none
module dual_timer_checker (
  // Clock, reset and bus
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Pins and requests
  input wire logic        stop_recovery,
  input wire logic        port3_bit4_data,
  input wire logic        port3_bit4_pin,
  input wire logic        narrow_output_level,
  input wire logic        narrow_timeout_irq,
  input wire logic        wide_timeout_irq,
  input wire logic        wide_capture_irq
);
  import dual_timer_pkg::*;
  logic       wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic       n_sel_reg;
  logic       n_ie_reg;
  logic       w_ie_reg;
  logic       w_cie_reg;
  // Address phases taken by the slave
  wire logic take_wr = hsel && htrans[1] && hready && hwrite;
  wire logic take_rd = hsel && htrans[1] && hready && !hwrite;
  wire logic n_hit   = wr_pend_reg && (wr_addr_reg == OFS_NARROW_CTRL);
  wire logic w_hit   = wr_pend_reg && (wr_addr_reg == OFS_WIDE_CTRL);
  // Shadow bits; stop recovery drops only the pin select
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      n_sel_reg   <= 1'b0;
      n_ie_reg    <= 1'b0;
      w_ie_reg    <= 1'b0;
      w_cie_reg   <= 1'b0;
    end else begin
      wr_pend_reg <= take_wr;
      wr_addr_reg <= haddr[7:0];
      if (n_hit) begin
        n_sel_reg <= hwdata[B_PIN_SEL];
        n_ie_reg  <= hwdata[B_TO_IE];
      end else if (stop_recovery) begin
        n_sel_reg <= 1'b0;
      end
      if (w_hit) begin
        w_ie_reg  <= hwdata[B_TO_IE];
        w_cie_reg <= hwdata[B_CAP_IE];
      end
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  chk_read_hold: assert property (!take_rd |=> $stable(hrdata))
    else $error("read data moved");
  chk_pin_port: assert property (
    !n_sel_reg |=> port3_bit4_pin == $past(port3_bit4_data))
    else $error("pin not port data");
  chk_pin_timer: assert property (
    (n_sel_reg && $stable(narrow_output_level)) [*3] |-> port3_bit4_pin == narrow_output_level)
    else $error("pin not timer level");
  chk_narrow_irq_gate: assert property (
    narrow_timeout_irq |-> n_ie_reg || $past(n_ie_reg))
    else $error("narrow irq disabled");
  chk_wide_irq_gate: assert property (
    wide_timeout_irq |-> w_ie_reg || $past(w_ie_reg))
    else $error("wide irq disabled");
  chk_capture_pulse: assert property (wide_capture_irq |=> !wide_capture_irq)
    else $error("capture irq too long");
  chk_capture_gate: assert property (
    wide_capture_irq |-> w_cie_reg || $past(w_cie_reg))
    else $error("capture irq disabled");
  cov_narrow: cover property ($rose(narrow_timeout_irq));
  cov_wide: cover property ($rose(wide_timeout_irq));
  cov_capture: cover property (wide_capture_irq);
endmodule
bind dual_timer dual_timer_checker chk (.*);
`default_nettype wire

// *** tb/carrier_source.sv ***
// Carrier burst source standing in for the receiver front end
`timescale 1ns/10ps
`default_nettype none
module carrier_source (
  // Clock and burst request
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  // Carrier pin
  output logic            carrier_in
);
  int n = 0;
  int gap = 0;
  initial carrier_in = 1'b0;
  // Four clocks per half pulse so every edge clears the synchroniser
  always @(posedge hclk) begin
    if (go) begin
      n   <= 2 * pulses;
      gap <= 0;
    end else if (n > 0) begin
      gap <= (gap == 3) ? 0 : gap + 1;
      if (gap == 3) begin
        carrier_in <= ~carrier_in;
        n          <= n - 1;
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/dual_timer_pingpong_capture_bench.sv ***
// Self-checking bench for the dual down-counter timer
`timescale 1ns/10ps
`default_nettype none
module dual_timer_pingpong_capture_bench;
  import dual_timer_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic        hclk, hresetn, hsel, hwrite, stop_recovery, port3_bit4_data, go;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [3:0]  pulses;
  logic        hreadyout, hresp, carrier_in, port3_bit4_pin;
  logic        narrow_output_level, wide_output_level;
  logic        narrow_timeout_irq, wide_timeout_irq, wide_capture_irq;
  wire logic   hready = hreadyout;
  int          n_fail = 0, comparisons = 0, caps = 0, n;
  row_s rows [12] = '{'{OFS_NARROW_CTRL, 32'h7F, 32'h5F}, '{OFS_SHARED_CTRL, 32'hBF, 32'hBF},
    '{OFS_WIDE_CTRL, 32'h7F, 32'h46}, '{OFS_N_RELOAD_HI, 32'h1A5, 32'hA5},
    '{OFS_N_RELOAD_LO, 32'h3C, 32'h3C}, '{OFS_W_RELOAD_HI, 32'h12, 32'h12},
    '{OFS_W_RELOAD_LO, 32'h34, 32'h34}, '{OFS_CAPTURE, 32'hFFFF, 32'h0},
    '{8'h20, 32'h5A, 32'h0}, '{OFS_NARROW_CTRL, 32'h0, 32'h0},
    '{OFS_SHARED_CTRL, 32'h0, 32'h0}, '{OFS_WIDE_CTRL, 32'h0, 32'h0}};
  dual_timer uut (.*, .hsize(3'b010));
  carrier_source partner (.*);
  // 20 MHz clock
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Capture pulses last one cycle; count them as they pass
  always @(posedge hclk) if (wide_capture_irq === 1'b1) caps++;
  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  // One single AHB transfer; entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    hwrite <= w;
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string what);
    bus(1'b0, a, 32'h0);
    check(what, e, q);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return narrow_timeout_irq;
      1: return wide_timeout_irq;
      2: return narrow_output_level;
      default: return wide_output_level;
    endcase
  endfunction
  // Cycles until the picked output is high
  task automatic wait_hi(input int k, output int c);
    c = 0;
    while (c < 300 && pick(k) !== 1'b1) begin
      @(posedge hclk);
      c++;
    end
  endtask
  // Cycles until the narrow level changes
  task automatic gap(output int c);
    logic l;
    l = narrow_output_level;
    c = 0;
    while (c < 300 && narrow_output_level === l) begin
      @(posedge hclk);
      c++;
    end
  endtask
  task automatic burst(input logic [3:0] k);
    go     <= 1'b1;
    pulses <= k;
    @(posedge hclk);
    go <= 1'b0;
    repeat (8 * k + 12) @(posedge hclk);
  endtask
  // Watchdog far past the run length
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, stop_recovery, port3_bit4_data, go} = 6'b0;
    {haddr, hwdata, htrans, pulses} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    check("irq lines", 32'h0, {29'h0, narrow_timeout_irq, wide_timeout_irq, wide_capture_irq});
    for (int i = 0; i < 36; i += 4) rd(8'(i), 32'h0, "reset value");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "readback");
    end
    // Pin: port data first, then the idle timer level
    port3_bit4_data <= 1'b1;
    repeat (3) @(posedge hclk);
    check("port pin", 32'h1, {31'h0, port3_bit4_pin});
    wr(OFS_NARROW_CTRL, 32'h01);
    repeat (3) @(posedge hclk);
    check("timer pin", 32'h0, {31'h0, port3_bit4_pin});
    wr(OFS_NARROW_CTRL, 32'h00);
    // Modulo: toggles (reload + 1) ticks apart
    wr(OFS_N_RELOAD_HI, 32'h3);
    wr(OFS_N_RELOAD_LO, 32'h3);
    for (int s = 0; s < 4; s++) begin
      wr(OFS_NARROW_CTRL, 32'(32'h82 | (s << B_CLKSEL)));
      gap(n);
      gap(n);
      check("toggle spacing", 32'(4 << s), 32'(n));
    end
    check("timeout irq", 32'h1, {31'h0, narrow_timeout_irq});
    wr(OFS_NARROW_CTRL, 32'h22);
    rd(OFS_NARROW_CTRL, 32'h02, "flag cleared");
    // Single pass; a restart drops the old count
    wr(OFS_N_RELOAD_LO, 32'h9);
    wr(OFS_NARROW_CTRL, 32'hC2);
    repeat (2) @(posedge hclk);
    wr(OFS_NARROW_CTRL, 32'h42);
    wr(OFS_NARROW_CTRL, 32'hC2);
    wait_hi(0, n);
    check("restart delay", 32'h1, {31'h0, n >= 10 && n <= 13});
    rd(OFS_NARROW_CTRL, 32'h62, "single stop");
    // Receive mode wrap from zero
    wr(OFS_W_RELOAD_HI, 32'h0);
    wr(OFS_W_RELOAD_LO, 32'h10);
    wr(OFS_WIDE_CTRL, 32'h82);
    wait_hi(1, n);
    check("wrap delay", 32'h1, {31'h0, n >= 16 && n <= 20});
    rd(OFS_WIDE_CTRL, 32'hA2, "wrap flag");
    wr(OFS_WIDE_CTRL, 32'h20);
    // Capture per edge, once when armed, then on narrow timeout
    wr(OFS_SHARED_CTRL, 32'h10);
    wr(OFS_W_RELOAD_HI, 32'hFF);
    wr(OFS_W_RELOAD_LO, 32'hFF);
    wr(OFS_WIDE_CTRL, 32'h84);
    burst(4'd2);
    wr(OFS_WIDE_CTRL, 32'hC4);
    burst(4'd3);
    check("edge captures", 32'd3, 32'(caps));
    wr(OFS_N_RELOAD_LO, 32'h4);
    wr(OFS_NARROW_CTRL, 32'hE0);
    repeat (30) @(posedge hclk);
    check("timeout capture", 32'd4, 32'(caps));
    // Ping-pong: stop and clear first, enable last
    wr(OFS_WIDE_CTRL, 32'h20);
    wr(OFS_NARROW_CTRL, 32'h20);
    wr(OFS_SHARED_CTRL, 32'h87);
    wr(OFS_N_RELOAD_HI, 32'h6);
    wr(OFS_N_RELOAD_LO, 32'h9);
    wr(OFS_W_RELOAD_HI, 32'h0);
    wr(OFS_W_RELOAD_LO, 32'h8);
    wr(OFS_WIDE_CTRL, 32'h42);
    wr(OFS_NARROW_CTRL, 32'hC2);
    wait_hi(2, n);
    check("start level", 32'h1, {31'h0, n <= 2});
    wait_hi(0, n);
    check("high reload", 32'h1, {31'h0, n >= 6 && n <= 8});
    wait_hi(3, n);
    check("wide level", 32'h1, {31'h0, n <= 3});
    wait_hi(1, n);
    check("wide timeout", 32'h1, {31'h0, n <= 15});
    rd(OFS_NARROW_CTRL, 32'hE2, "narrow restart");
    wr(OFS_SHARED_CTRL, 32'h83);
    repeat (40) @(posedge hclk);
    for (int i = 0; i < 8; i++) rd(OFS_NARROW_CTRL, 32'h62, "ping-pong ended");
    // Stop recovery keeps irq enable; reset clears it
    wr(OFS_NARROW_CTRL, 32'h5F);
    stop_recovery <= 1'b1;
    @(posedge hclk);
    stop_recovery <= 1'b0;
    rd(OFS_NARROW_CTRL, 32'h3E, "stop recovery");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_NARROW_CTRL, 32'h00, "after reset");
    test_done();
  end
endmodule
`default_nettype wire
